// ===== core/rsl_top.sv
/*
 * Run enable and status logic of a thermoelectric controller.
 * Assumes pin levels are synchronous to sys_clk; analog values are
 * digitised elsewhere into millivolt and centidegree codes.
 */
// Overview of operation
// (RQ1) The run request pin defaults to active low, so an open (high) pin is inactive.
// (RQ2) An active run request permitted by the run mode starts regulation and power stage.
// (RQ3) In software run mode run enable needs both run request and software start.
// (RQ4) In hardware run mode the software start is ignored and the run request alone counts.
// (RQ5) The clear pin defaults to active low, open reads inactive, and clears latched errors.
// (RQ6) The clear pin touches only error states, never configuration or boot state.
// (RQ7) Healthy and in-band pins default to active high.
// (RQ8) Healthy stays inactive from reset until the boot sequence is done; reset drives the pin low, the active level when healthy_pol_low is set.
// (RQ9) Healthy is active only in normal operation with no error pending.
// (RQ10) In-band is active only while enabled and within one degree of the setpoint; reset drives the pin low, active when in_band_pol_low is set.
// (RQ11) The analog target is used only when the target source is hardware, the default.
// (RQ12) The target is ten degrees per volt of the analog target input.
// (RQ13) A sensor voltage below 0.08 V or above 2.35 V raises a sensor error.
// (RQ14) The spare target input is ignored.
// (RQ15) Overcurrent and power stage overtemperature are separate error states.
// (RQ16) Errors stay latched, blocking healthy and run, until cleared with the cause gone.
`timescale 1ns/10ps
`default_nettype none
module rsl_top
(
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       run_request_pin,
    input  wire logic                       error_clear_pin,
    input  wire logic                       run_pol_high,
    input  wire logic                       clr_pol_high,
    input  wire logic                       healthy_pol_low,
    input  wire logic                       in_band_pol_low,
    input  wire logic                       run_mode_sw,
    input  wire logic                       sw_start,
    input  wire logic                       target_source_select,
    input  wire logic [rsl_pkg::MV_W-1:0]   analog_target_in,
    input  wire logic [rsl_pkg::MV_W-1:0]   spare_target_in,
    input  wire logic [rsl_pkg::TEMP_W-1:0] sw_target,
    input  wire logic [rsl_pkg::TEMP_W-1:0] measured_temp,
    input  wire logic [rsl_pkg::MV_W-1:0]   sensor_mv,
    input  wire logic                       overcurrent,
    input  wire logic                       overtemp,
    output logic                            run_enable,
    output logic                            healthy_pin,
    output logic                            in_band_pin,
    output logic      [rsl_pkg::TEMP_W-1:0] target_temp,
    output logic      [rsl_pkg::ERR_W-1:0]  error_state,
    output logic                            boot_done
);
    // ==========================================================
    // Functions
    function automatic logic level_active(input logic lvl, input logic pol_high);
        level_active = pol_high ? lvl : ~lvl;
    endfunction

    function automatic logic drive_level(input logic active, input logic pol_low);
        drive_level = active ^ pol_low;
    endfunction

    function automatic logic [rsl_pkg::TEMP_W-1:0] abs_diff
    (
        input logic [rsl_pkg::TEMP_W-1:0] a,
        input logic [rsl_pkg::TEMP_W-1:0] b
    );
        abs_diff = ($signed(a) >= $signed(b)) ? a - b : b - a;
    endfunction

    // ==========================================================
    // Declarations
    rsl_pkg::rsl_state_t              state;
    logic [rsl_pkg::BOOT_CNT_W-1:0]   boot_cnt;
    logic                             external_run_request;
    logic                             external_error_clear;
    logic [rsl_pkg::ERR_W-1:0]        cause;
    logic                             sensor_bad;
    logic [rsl_pkg::TEMP_W-1:0]       diff;
    logic                             next_run;
    logic                             next_band;
    logic                             next_healthy;
    logic                             boot_last;
    logic                             err_block;
    logic [rsl_pkg::TEMP_W-1:0]       scaled_target;

    // ==========================================================
    // Input decoding
    assign external_run_request = level_active(run_request_pin,
                                               run_pol_high ^ rsl_pkg::RUN_POL_RST); // [RQ1]
    assign external_error_clear = level_active(error_clear_pin,
                                               clr_pol_high ^ rsl_pkg::CLR_POL_RST); // [RQ5]

    // ==========================================================
    // Error causes
    assign sensor_bad = (sensor_mv < rsl_pkg::SENSOR_MIN_MV)
                      || (sensor_mv > rsl_pkg::SENSOR_MAX_MV); // [RQ13]
    always_comb
    begin
        cause = '0;
        cause[rsl_pkg::ERR_SENSOR]   = sensor_bad;
        cause[rsl_pkg::ERR_CURRENT]  = overcurrent; // [RQ15]
        cause[rsl_pkg::ERR_OVERTEMP] = overtemp;    // [RQ15]
    end

    // Clear reaches only the error latch [RQ6]
    rsl_err_latch u_err
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .cause   (cause),
        .clear   (external_error_clear),
        .latched (error_state)
    );

    // ==========================================================
    // Boot counter
    assign boot_last = (boot_cnt == rsl_pkg::BOOT_CNT_W'(rsl_pkg::BOOT_CYCLES - 1));
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            boot_cnt <= '0;
        else if (clk_en && (state == rsl_pkg::RSL_BOOT) && !boot_last)
            boot_cnt <= boot_cnt + 1'b1; // [RQ8]
    end

    // ==========================================================
    // Boot sequencing
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            state <= rsl_pkg::RSL_BOOT;
        else if (clk_en)
        begin
            case (state)
                rsl_pkg::RSL_BOOT:
                begin
                    if (boot_last)
                        state <= rsl_pkg::RSL_NORMAL; // [RQ8]
                end
                rsl_pkg::RSL_NORMAL:
                begin
                    if (|error_state)
                        state <= rsl_pkg::RSL_FAULT;
                end
                rsl_pkg::RSL_FAULT:
                begin
                    if (~|error_state)
                        state <= rsl_pkg::RSL_NORMAL;
                end
                default:
                    state <= rsl_pkg::RSL_BOOT;
            endcase
        end
    end
    assign boot_done = (state != rsl_pkg::RSL_BOOT);

    // ==========================================================
    // Error gating
    assign err_block = (|error_state) || (|cause); // [RQ16]

    // ==========================================================
    // Run enable
    always_comb
    begin
        next_run = external_run_request
                   && (run_mode_sw ? sw_start : 1'b1); // [RQ3] [RQ4]
        next_run = next_run && (state == rsl_pkg::RSL_NORMAL)
                   && !err_block; // [RQ16]
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            run_enable <= 1'b0;
        else if (clk_en)
            run_enable <= next_run; // [RQ2]
    end

    // ==========================================================
    // Target temperature
    assign scaled_target = rsl_pkg::TEMP_W'(analog_target_in * rsl_pkg::CDEG_PER_MV); // [RQ12]
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            target_temp <= '0;
        else if (clk_en)
        begin
            if (target_source_select == rsl_pkg::RSL_TGT_HW) // [RQ11] [RQ14]
                target_temp <= scaled_target;
            else
                target_temp <= sw_target;
        end
    end

    // ==========================================================
    // Status decoding
    always_comb
    begin
        diff = abs_diff(measured_temp, target_temp);
        next_band = run_enable && (diff <= rsl_pkg::BAND_CDEG); // [RQ10]
        next_healthy = (state == rsl_pkg::RSL_NORMAL) && ~|error_state; // [RQ8] [RQ9]
    end

    // ==========================================================
    // Healthy output
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            healthy_pin <= ~rsl_pkg::HEALTHY_POL_RST;
        else if (clk_en)
            healthy_pin <= drive_level(next_healthy,
                                       healthy_pol_low ^ ~rsl_pkg::HEALTHY_POL_RST); // [RQ7]
    end

    // ==========================================================
    // In-band output
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            in_band_pin <= ~rsl_pkg::IN_BAND_POL_RST;
        else if (clk_en)
            in_band_pin <= drive_level(next_band,
                                       in_band_pol_low ^ ~rsl_pkg::IN_BAND_POL_RST); // [RQ7]
    end
endmodule
`default_nettype wire

// ===== shared/rsl_pkg.sv
/*
 * Constants for the run enable and status logic: polarities, scaling,
 * sensor window and boot timing.
 * Assumes analog quantities arrive as unsigned millivolt codes and
 * temperatures as signed centidegree codes.
 */
`default_nettype none
package rsl_pkg;
    // ==========================================================
    // Clock and timing
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          BOOT_TIME_US    = 1000;
    localparam int          BOOT_CYCLES     = BOOT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          BOOT_CNT_W      = 16;
    // ==========================================================
    // Data widths
    localparam int          MV_W            = 13;
    localparam int          TEMP_W          = 16;
    // ==========================================================
    // Default polarities (1 = active high)
    localparam logic        RUN_POL_RST     = 1'h0;
    localparam logic        CLR_POL_RST     = 1'h0;
    localparam logic        HEALTHY_POL_RST = 1'h1;
    localparam logic        IN_BAND_POL_RST = 1'h1;
    // ==========================================================
    // Setpoint scaling: 10 degC per volt = 1 centidegree per millivolt
    localparam int          CDEG_PER_MV     = 1;
    localparam logic [15:0] BAND_CDEG       = 16'h0064;
    // ==========================================================
    // Sensor window in millivolts
    localparam logic [12:0] SENSOR_MIN_MV   = 13'h0050;
    localparam logic [12:0] SENSOR_MAX_MV   = 13'h092e;
    // ==========================================================
    // Error bit positions
    localparam int          ERR_SENSOR      = 0;
    localparam int          ERR_CURRENT     = 1;
    localparam int          ERR_OVERTEMP    = 2;
    localparam int          ERR_W           = 3;
    // ==========================================================
    // Modes
    typedef enum logic { RSL_RUN_HW, RSL_RUN_SW } rsl_run_mode_t;
    typedef enum logic { RSL_TGT_HW, RSL_TGT_SW } rsl_tgt_mode_t;
    typedef enum logic [1:0] { RSL_BOOT, RSL_NORMAL, RSL_FAULT } rsl_state_t;
endpackage
`default_nettype wire

// ===== core/rsl_err_latch.sv
/*
 * Sticky error latch: one bit per error cause, cleared by a clear
 * strobe only when the cause has gone.
 * Assumes causes and clear are synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module rsl_err_latch
(
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    input  wire logic [rsl_pkg::ERR_W-1:0] cause,
    input  wire logic                    clear,
    output logic      [rsl_pkg::ERR_W-1:0] latched
);
    // ==========================================================
    // Latch
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            latched <= '0;
        else if (clk_en)
            latched <= cause | (clear ? '0 : latched); // [RQ16] [RQ5]
    end
endmodule
`default_nettype wire

// ===== test/rsl_checker.sv
/* Port-level assertions for rsl_top.
   Assumes it is bound to every rsl_top instance. */
`timescale 1ns/10ps
`default_nettype none
module rsl_checker
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic        run_request_pin,
    input wire logic        error_clear_pin,
    input wire logic        run_pol_high,
    input wire logic        clr_pol_high,
    input wire logic        healthy_pol_low,
    input wire logic        in_band_pol_low,
    input wire logic        run_mode_sw,
    input wire logic        sw_start,
    input wire logic        target_source_select,
    input wire logic [12:0] analog_target_in,
    input wire logic [12:0] sensor_mv,
    input wire logic        overcurrent,
    input wire logic        run_enable,
    input wire logic        healthy_pin,
    input wire logic        in_band_pin,
    input wire logic [15:0] target_temp,
    input wire logic [2:0]  error_state,
    input wire logic        boot_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Assertions
    boot_run_a: assert property (!boot_done |-> !run_enable)
        else $error("run enable during boot");
    boot_health_a: assert property (!boot_done && !healthy_pol_low |=> !healthy_pin)
        else $error("healthy during boot");
    idle_run_a: assert property (clk_en && run_request_pin != run_pol_high |=> !run_enable)
        else $error("run enable without request");
    sw_gate_a: assert property (clk_en && run_mode_sw && !sw_start |=> !run_enable)
        else $error("run enable without start");
    err_run_a: assert property (|error_state |-> !run_enable)
        else $error("run enable with error");
    err_health_a: assert property (clk_en && |error_state && !healthy_pol_low
        |=> !healthy_pin)
        else $error("healthy with error");
    sensor_low_a: assert property (clk_en && sensor_mv < rsl_pkg::SENSOR_MIN_MV
        |=> error_state[0])
        else $error("sensor short missed");
    cur_err_a: assert property (clk_en && overcurrent |=> error_state[1])
        else $error("overcurrent missed");
    err_sticky_a: assert property (error_state[1] && error_clear_pin != clr_pol_high
        |=> error_state[1])
        else $error("error bit lost");
    band_off_a: assert property (clk_en && !run_enable && !in_band_pol_low
        |=> !in_band_pin)
        else $error("in band while disabled");
    tgt_scale_a: assert property (clk_en && !target_source_select
        |=> target_temp == {3'h0, $past(analog_target_in)})
        else $error("target scaling wrong");
    freeze_hold_a: assert property (!clk_en
        |=> $stable(run_enable) && $stable(healthy_pin) && $stable(error_state))
        else $error("state moved while frozen");
    cover property (boot_done && run_enable && in_band_pin);
    cover property (error_state[0] && !healthy_pin);
    cover property (run_mode_sw && sw_start && run_enable);
endmodule
bind rsl_top rsl_checker i_chk (.sys_clk, .sys_rst, .clk_en, .run_request_pin, .error_clear_pin,
    .run_pol_high, .clr_pol_high, .healthy_pol_low, .in_band_pol_low, .run_mode_sw, .sw_start,
    .target_source_select, .analog_target_in, .sensor_mv, .overcurrent, .run_enable,
    .healthy_pin, .in_band_pin, .target_temp, .error_state, .boot_done);
`default_nettype wire

// ===== test/rsl_partner.sv
/* Control contacts at the terminal side: run request and error clear.
   Assumes pulled-up inputs, so an idle contact rests high at low-active polarity and low at high-active polarity. */
`timescale 1ns/10ps
`default_nettype none
module rsl_partner
(
    input  wire logic run_on,
    input  wire logic clr_on,
    input  wire logic run_pol_high,
    input  wire logic clr_pol_high,
    output logic      run_request_pin,
    output logic      error_clear_pin
);
    // Idle level is the inactive one: high at low-active polarity, low at high-active polarity
    assign run_request_pin = run_pol_high ? run_on : ~run_on;
    assign error_clear_pin = clr_pol_high ? clr_on : ~clr_on;
endmodule
`default_nettype wire

// ===== test/rsl_top_test.sv
/* Self-checking bench for rsl_top with the contact model.
   Assumes the package boot time of 40000 cycles. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module rsl_top_test;
    logic        sys_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, run_on = 1'h1, clr_on = 1'h0;
    logic        run_pol_high = 1'h0, clr_pol_high = 1'h0, healthy_pol_low = 1'h0;
    logic        in_band_pol_low = 1'h0, run_mode_sw = 1'h0, sw_start = 1'h0;
    logic        target_source_select = 1'h0, overcurrent = 1'h0, overtemp = 1'h0;
    logic [12:0] analog_target_in = 13'h1388, spare_target_in = 13'h1fff, sensor_mv = 13'h03e8;
    logic [15:0] sw_target = 16'h0bb8, measured_temp = 16'h1388, target_temp;
    logic [2:0]  error_state;
    logic        run_request_pin, error_clear_pin, run_enable, healthy_pin, in_band_pin;
    logic        boot_done;
    logic [12:0] sv [4] = '{13'h004f, 13'h0050, 13'h092e, 13'h092f};
    logic        ev [4] = '{1'h1, 1'h0, 1'h0, 1'h1};
    int          mismatches = 0, tests_run = 0, cyc = 0, n = 0;
    always #12.5 sys_clk = ~sys_clk;
    rsl_partner i_far (.run_on, .clr_on, .run_pol_high, .clr_pol_high, .run_request_pin,
        .error_clear_pin);
    rsl_top i_dut (.sys_clk, .sys_rst, .clk_en, .run_request_pin, .error_clear_pin,
        .run_pol_high, .clr_pol_high, .healthy_pol_low, .in_band_pol_low, .run_mode_sw,
        .sw_start, .target_source_select, .analog_target_in, .spare_target_in, .sw_target,
        .measured_temp, .sensor_mv, .overcurrent, .overtemp, .run_enable, .healthy_pin,
        .in_band_pin, .target_temp, .error_state, .boot_done);
    task automatic step(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 42000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        step(3);
        sys_rst = 1'h0;
        step(2);
        `CHK(healthy_pin, 1'h0)
        `CHK(run_enable, 1'h0)
        while (boot_done !== 1'h1 && n < 41000)
        begin
            step(1);
            n++;
        end
        $display("Boot test done");
        spare_target_in = 13'h0000;
        step(4);
        `CHK(healthy_pin, 1'h1)
        `CHK(run_enable, 1'h1)
        `CHK(target_temp, 16'h1388)
        `CHK(in_band_pin, 1'h1)
        target_source_select = 1'h1;
        step(4);
        `CHK(target_temp, 16'h0bb8)
        `CHK(in_band_pin, 1'h0)
        measured_temp = 16'h0c1c;
        step(4);
        `CHK(in_band_pin, 1'h1)
        in_band_pol_low = 1'h1;
        step(4);
        `CHK(in_band_pin, 1'h0)
        in_band_pol_low = 1'h0;
        measured_temp = 16'h0c1d;
        step(4);
        `CHK(in_band_pin, 1'h0)
        $display("Setpoint and band test done");
        run_on = 1'h0;
        step(4);
        `CHK(run_enable, 1'h0)
        run_on = 1'h1;
        run_mode_sw = 1'h1;
        step(4);
        `CHK(run_enable, 1'h0)
        sw_start = 1'h1;
        step(4);
        `CHK(run_enable, 1'h1)
        run_mode_sw = 1'h0;
        sw_start = 1'h0;
        run_pol_high = 1'h1;
        step(4);
        `CHK(run_enable, 1'h1)
        run_on = 1'h0;
        step(4);
        `CHK(run_enable, 1'h0)
        run_pol_high = 1'h0;
        run_on = 1'h1;
        step(4);
        `CHK(run_enable, 1'h1)
        clk_en = 1'h0;
        run_on = 1'h0;
        healthy_pol_low = 1'h1;
        step(4);
        `CHK(run_enable, 1'h1)
        `CHK(healthy_pin, 1'h1)
        clk_en = 1'h1;
        step(2);
        `CHK(run_enable, 1'h0)
        `CHK(healthy_pin, 1'h0)
        healthy_pol_low = 1'h0;
        run_on = 1'h1;
        $display("Run source test done");
        for (int i = 0; i < 4; i++)
        begin
            clr_pol_high = 1'(i);
            sensor_mv = sv[i];
            step(3);
            `CHK(error_state[0], ev[i])
            sensor_mv = 13'h03e8;
            clr_on = 1'h1;
            step(3);
            clr_on = 1'h0;
            `CHK(error_state, 3'h0)
        end
        clr_pol_high = 1'h0;
        overcurrent = 1'h1;
        step(3);
        `CHK(error_state, 3'h2)
        `CHK(run_enable, 1'h0)
        `CHK(healthy_pin, 1'h0)
        overcurrent = 1'h0;
        overtemp = 1'h1;
        step(3);
        `CHK(error_state, 3'h6)
        clr_on = 1'h1;
        step(3);
        `CHK(error_state, 3'h4)
        overtemp = 1'h0;
        step(3);
        `CHK(error_state, 3'h0)
        clr_on = 1'h0;
        `CHK(boot_done, 1'h1)
        step(4);
        `CHK(healthy_pin, 1'h1)
        `CHK(run_enable, 1'h1)
        $display("Error latch test done");
        end_sim();
    end
endmodule
`default_nettype wire
